// >>> logic/pic_counter.sv
// Two-channel pulse integration and rotational speed counter
`timescale 1ns/100ps
`default_nettype none
`include "pic_defs.svh"
// Notes on behaviour
// - Cumulative mode, the default, adds every qualified pulse from start with no interval clear.
// - Per-interval mode clears the count at each interval start and reports that interval only.
// - Speed mode reports qualified pulses counted per second.
// - Integration modes pick one of five ranges from 2500 to 125M counts, 2500 after reset.
// - Speed mode ignores the range and reports a fixed 250 r/s per division.
// - An optional chatter filter, off after reset, rejects contact bounce before edge detection.
// - A divider of 1 to 50000, default 1, sets input pulses per counted unit; 1 means no division.
// - Edge select counts rising edges by default or falling edges when set.
// - Zero timing starts integration at measurement start by default, or after the trigger.
// - With trigger timing on the trigger source channel, count from start, clear at the sample after the trigger, go on.
// - With trigger timing on a non-source channel, the output is zero until after the clear sample that follows the trigger.
// - The trigger sample keeps the old value, the next sample clears, the second shows results.
// - The two logic groups share one enable, so turning on either turns on both.
// - Cumulative mode with hold saturates at 65535.
// - Cumulative mode with wrap returns to zero at twenty ranges, keeping the excess.
// - Speed is a 10 ms reading summed over a sliding 1 s window.
module pic_counter #(
   parameter int TICK_CYC    = `PIC_TICK_CYC,
   parameter int CHATTER_CYC = `PIC_CHATTER_CYC
) (
   input  wire logic              ref_clk,           // 200 MHz clock
   input  wire logic              rstn,              // Async reset, active low
   input  wire logic [1:0]        pulse_input_pin,   // Pins one (0) and two (1)
   input  wire logic              meas_start,        // Measurement start pulse
   input  wire logic              meas_run,          // Measurement running level
   input  wire logic              sample_strobe,     // Recording sample pulse
   input  wire logic              trig_event,        // Trigger applied pulse
   input  wire logic [1:0]        trig_source,       // Channel is trigger source
   input  wire logic [3:0]        cfg_mode,          // Mode per channel, 2 bits each
   input  wire logic [5:0]        cfg_range,         // Range index per channel, 3 bits each
   input  wire logic [1:0]        cfg_filter,        // Chatter filter on
   input  wire logic [31:0]       cfg_division,      // Divider per channel, 16 bits each
   input  wire logic [1:0]        cfg_fall,          // Count falling edges
   input  wire logic [1:0]        cfg_trig_timing,   // Zero at trigger
   input  wire logic [1:0]        cfg_wrap,          // Wrap instead of hold
   input  wire logic              logic_group_first_en,  // First logic group use
   input  wire logic              logic_group_second_en, // Second logic group use
   output logic                   logic_meas_en,     // Shared logic enable
   output logic      [63:0]       chan_value,        // Sampled value per channel
   output logic      [63:0]       chan_full_scale    // Per-division scale per channel
);
   localparam int SLOTS = `PIC_WIN_SLOTS;
   // The slot pointer is seven bits wide
   if (TICK_CYC < 1 || CHATTER_CYC < 1 || SLOTS < 1 || SLOTS > 128) begin : g_bad_param
      $error("pic_counter: timing counts out of range");
   end

   // ----------------------------------------
   // Shared logic enable
   // ----------------------------------------
   assign logic_meas_en = logic_group_first_en | logic_group_second_en;

   // ----------------------------------------
   // Common 10 ms tick
   // ----------------------------------------
   logic [31:0] tick_cnt_q;
   logic        tick;
   assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) tick_cnt_q <= 32'h0;
      else if (meas_start || tick) tick_cnt_q <= 32'h0;
      else tick_cnt_q <= tick_cnt_q + 32'h1;
   end

   function automatic logic [31:0] range_of(input logic [2:0] idx);
      unique case (idx)
         3'h0: range_of = `PIC_RANGE_0;
         3'h1: range_of = `PIC_RANGE_1;
         3'h2: range_of = `PIC_RANGE_2;
         3'h3: range_of = `PIC_RANGE_3;
         3'h4: range_of = `PIC_RANGE_4;
         default: range_of = `PIC_RANGE_0;
      endcase
   endfunction : range_of

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      pic_pkg::pic_mode_t mode;
      logic [15:0] div;
      logic [1:0]  pin_s;
      logic        filt_q;
      logic [31:0] stab_q;
      logic        qual, qual_q, edge_hit, unit;
      logic [15:0] pre_q;
      logic [31:0] acc_q, wrap_lim;
      logic [23:0] slot_q, sum_q, old_slot;
      logic [6:0]  slot_ptr_q;
      logic        fill_q;
      pic_pkg::pic_trg_t trg_q;
      logic        zero_gate;
      logic [31:0] raw;

      assign mode = pic_pkg::pic_mode_t'(cfg_mode[2*c +: 2]);
      assign div  = (cfg_division[16*c +: 16] == 16'h0) ? `PIC_DIV_RST
                                                       : cfg_division[16*c +: 16];

      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) pin_s <= 2'h0;
         else pin_s <= {pin_s[0], pulse_input_pin[c]};
      end

      // Level must hold steady for the whole window; costs that much latency
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            stab_q <= 32'h0;
            filt_q <= 1'b0;
         end else if (pin_s[1] == filt_q) begin
            stab_q <= 32'h0;
         end else if (stab_q == 32'(CHATTER_CYC - 1)) begin
            filt_q <= pin_s[1];
            stab_q <= 32'h0;
         end else begin
            stab_q <= stab_q + 32'h1;
         end
      end

      assign qual = cfg_filter[c] ? filt_q : pin_s[1];
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) qual_q <= 1'b0;
         else qual_q <= qual;
      end
      assign edge_hit = meas_run && (cfg_fall[c] ? (qual_q && !qual)
                                                 : (!qual_q && qual));

      // Prescaler: one unit per div qualified edges
      assign unit = edge_hit && (pre_q == div - 16'h1);
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) pre_q <= 16'h0;
         else if (meas_start) pre_q <= 16'h0;
         else if (unit) pre_q <= 16'h0;
         else if (edge_hit) pre_q <= pre_q + 16'h1;
      end

      // Trigger sequencing: trigger sample, clear sample, then run
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) trg_q <= pic_pkg::PIC_TRG_IDLE;
         else if (meas_start) trg_q <= pic_pkg::PIC_TRG_IDLE;
         else begin
            unique case (trg_q)
               pic_pkg::PIC_TRG_IDLE:  if (trig_event) trg_q <= pic_pkg::PIC_TRG_CLEAR;
               pic_pkg::PIC_TRG_CLEAR: if (sample_strobe) trg_q <= pic_pkg::PIC_TRG_RUN;
               pic_pkg::PIC_TRG_RUN:   trg_q <= pic_pkg::PIC_TRG_RUN;
               default:                trg_q <= pic_pkg::PIC_TRG_IDLE;
            endcase
         end
      end
      // Non-source channels stay idle until the clear sample
      assign zero_gate = cfg_trig_timing[c] && !trig_source[c]
                         && trg_q != pic_pkg::PIC_TRG_RUN;

      assign wrap_lim = 32'(`PIC_WRAP_FACTOR) * range_of(cfg_range[3*c +: 3]);

      // Accumulator
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            acc_q <= 32'h0;
         end else if (meas_start) begin
            acc_q <= 32'h0;
         end else if (cfg_trig_timing[c] && trg_q == pic_pkg::PIC_TRG_CLEAR
                      && sample_strobe) begin
            acc_q <= {31'h0, unit};
         end else if (mode == pic_pkg::PIC_MODE_INSTANT && sample_strobe) begin
            acc_q <= {31'h0, unit && !zero_gate};
         end else if (unit && !zero_gate) begin
            if (mode == pic_pkg::PIC_MODE_ADD && cfg_wrap[c]
                && acc_q + 32'h1 >= wrap_lim) begin
               acc_q <= acc_q + 32'h1 - wrap_lim;
            end else if (mode == pic_pkg::PIC_MODE_ADD && !cfg_wrap[c]
                         && acc_q >= `PIC_HOLD_MAX) begin
               acc_q <= `PIC_HOLD_MAX;
            end else begin
               acc_q <= acc_q + 32'h1;
            end
         end
      end

      // Speed: 10 ms reading into a ring of 100 slots, running sum
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) slot_q <= 24'h0;
         else if (meas_start || tick) slot_q <= {23'h0, tick && unit};
         else if (unit) slot_q <= slot_q + 24'h1;
      end
      pic_ring_mem #(.DEPTH(SLOTS), .WIDTH(24), .AW(7)) i_pic_ring_mem (
         .ref_clk (ref_clk),
         .we      (tick),
         .addr    (slot_ptr_q),
         .wdata   (slot_q),
         .rdata   (old_slot)
      );
      // Sum update lags the write by a cycle to use the registered old slot
      logic        tick_q;
      logic [23:0] new_q;
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            tick_q     <= 1'b0;
            new_q      <= 24'h0;
            slot_ptr_q <= 7'h0;
            fill_q     <= 1'b0;
            sum_q      <= 24'h0;
         end else if (meas_start) begin
            tick_q     <= 1'b0;
            slot_ptr_q <= 7'h0;
            fill_q     <= 1'b0;
            sum_q      <= 24'h0;
         end else begin
            tick_q <= tick;
            new_q  <= slot_q;
            if (tick) begin
               slot_ptr_q <= (slot_ptr_q == 7'(SLOTS - 1)) ? 7'h0 : slot_ptr_q + 7'h1;
            end
            // Set a cycle after the wrap, so the last slot's unwritten old word is never used
            if (tick_q && slot_ptr_q == 7'h0) begin
               fill_q <= 1'b1;
            end
            if (tick_q) begin
               sum_q <= sum_q + new_q - (fill_q ? old_slot : 24'h0);
            end
         end
      end

      assign raw = (mode == pic_pkg::PIC_MODE_REVOLVE) ? {8'h0, sum_q} : acc_q;

      // Sampled output: trigger sample keeps prior value
      logic [31:0] value_q, scale_q;
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) value_q <= 32'h0;
         else if (meas_start) value_q <= 32'h0;
         else if (sample_strobe) value_q <= zero_gate ? 32'h0 : raw;
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) scale_q <= `PIC_RANGE_0;
         else scale_q <= (mode == pic_pkg::PIC_MODE_REVOLVE)
               ? `PIC_RPS_RANGE : range_of(cfg_range[3*c +: 3]);
      end
      // One register per channel keeps each output slice to a single driver
      assign chan_value[32*c +: 32]      = value_q;
      assign chan_full_scale[32*c +: 32] = scale_q;
   end
endmodule : pic_counter
`default_nettype wire

// >>> logic/pic_defs.svh
// Constants for the pulse integration counter
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_CLK_HZ         200000000
`define PIC_TICK_MS        10
`define PIC_TICK_CYC       ((`PIC_CLK_HZ / 1000) * `PIC_TICK_MS)
`define PIC_WIN_MS         1000
`define PIC_WIN_SLOTS      (`PIC_WIN_MS / `PIC_TICK_MS)
`define PIC_CHATTER_US     1000
`define PIC_CHATTER_CYC    ((`PIC_CLK_HZ / 1000000) * `PIC_CHATTER_US)
`define PIC_DIV_MAX        50000
`define PIC_DIV_RST        16'h0001
`define PIC_HOLD_MAX       32'h0000FFFF
`define PIC_WRAP_FACTOR    20
`define PIC_RANGE_0        32'h000009C4
`define PIC_RANGE_1        32'h000061A8
`define PIC_RANGE_2        32'h0003D090
`define PIC_RANGE_3        32'h004C4B40
`define PIC_RANGE_4        32'h07735940
`define PIC_RPS_RANGE      32'h000000FA
`endif

// >>> logic/pic_pkg.sv
// Types for the pulse integration counter
`default_nettype none
package pic_pkg;
   typedef enum logic [1:0] {
      PIC_MODE_ADD     = 2'h0,
      PIC_MODE_INSTANT = 2'h1,
      PIC_MODE_REVOLVE = 2'h3
   } pic_mode_t;
   typedef enum logic [1:0] {
      PIC_TRG_IDLE  = 2'h0,
      PIC_TRG_CLEAR = 2'h1,
      PIC_TRG_RUN   = 2'h3
   } pic_trg_t;
endpackage : pic_pkg
`default_nettype wire

// >>> logic/pic_ring_mem.sv
// Slot memory holding the 10 ms readings of the speed window
`timescale 1ns/100ps
`default_nettype none
module pic_ring_mem #(
   parameter int DEPTH = 100,
   parameter int WIDTH = 24,
   parameter int AW    = 7
) (
   input  wire logic             ref_clk,  // System clock
   input  wire logic             we,       // Write strobe
   input  wire logic [AW-1:0]    addr,     // Slot address
   input  wire logic [WIDTH-1:0] wdata,    // Write data
   output logic      [WIDTH-1:0] rdata     // Registered old data
);
   logic [WIDTH-1:0] mem [DEPTH];
   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
      $error("pic_ring_mem: address too narrow for depth");
   end
   // Read-before-write so the leaving slot is seen as it is replaced
   always_ff @(posedge ref_clk) begin
      rdata <= mem[addr];
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule : pic_ring_mem
`default_nettype wire

// >>> bench/pic_counter_monitor.sv
// Port-level assertions for the pulse integration counter
`timescale 1ns/100ps
`default_nettype none
module pic_counter_monitor (
   input wire logic        ref_clk,               // Clock
   input wire logic        rstn,                  // Reset
   input wire logic        meas_start,            // Start pulse
   input wire logic        sample_strobe,         // Sample pulse
   input wire logic        trig_event,            // Trigger pulse
   input wire logic [1:0]  trig_source,           // Source flags
   input wire logic [3:0]  cfg_mode,              // Modes
   input wire logic [5:0]  cfg_range,             // Ranges
   input wire logic [1:0]  cfg_trig_timing,       // Zero timing
   input wire logic [1:0]  cfg_wrap,              // Overflow handling
   input wire logic        logic_group_first_en,  // Group one use
   input wire logic        logic_group_second_en, // Group two use
   input wire logic        logic_meas_en,         // Shared enable
   input wire logic [63:0] chan_value,            // Values
   input wire logic [63:0] chan_full_scale        // Scales
);
   localparam logic [31:0] SC [5] = '{32'h000009C4, 32'h000061A8, 32'h0003D090,
                                      32'h004C4B40, 32'h07735940};
   logic wait_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Channel two waits for the trigger with its output parked at zero
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) wait_q <= 1'b0;
      else if (meas_start) wait_q <= cfg_trig_timing[1] & ~trig_source[1];
      else if (trig_event) wait_q <= 1'b0;
   end
   property p_en; logic_meas_en == (logic_group_first_en | logic_group_second_en); endproperty
   a_en: assert property (p_en) else $error("shared enable mismatch");
   property p_rev;
      cfg_mode[1:0] == 2'h3 && $stable(cfg_mode) && $past(rstn)
         |-> chan_full_scale[31:0] == 32'h000000FA;
   endproperty
   a_rev: assert property (p_rev) else $error("speed scale wrong");
   property p_rng;
      cfg_mode[3:2] != 2'h3 && $stable(cfg_mode) && $stable(cfg_range) && $past(rstn)
         |-> chan_full_scale[63:32] == SC[cfg_range[5:3]];
   endproperty
   a_rng: assert property (p_rng) else $error("range scale wrong");
   property p_stand;
      !$past(sample_strobe) && !$past(meas_start) && $past(rstn) |-> $stable(chan_value);
   endproperty
   a_stand: assert property (p_stand) else $error("value moved off sample");
   property p_start; $past(meas_start) && $past(rstn) |-> chan_value == 64'h0; endproperty
   a_start: assert property (p_start) else $error("start did not clear");
   property p_zero; wait_q && $past(wait_q) |-> chan_value[63:32] == 32'h0; endproperty
   a_zero: assert property (p_zero) else $error("nonzero before trigger");
   property p_hold;
      cfg_mode[1:0] == 2'h0 && !cfg_wrap[0] |-> chan_value[31:0] <= 32'h0000FFFF;
   endproperty
   a_hold: assert property (p_hold) else $error("hold limit passed");
   property p_wrap;
      cfg_mode[1:0] == 2'h0 && cfg_wrap[0] |-> chan_value[31:0] < 20 * chan_full_scale[31:0];
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap limit passed");
endmodule : pic_counter_monitor
`default_nettype wire

// >>> bench/pic_pulse_src.sv
// Behavioural pulse source standing in for meters and encoders
`timescale 1ns/100ps
`default_nettype none
module pic_pulse_src (
   input  wire logic       ref_clk, // Pacing only, the lines change on its falling edges
   output var  logic [1:0] pin      // Pulse lines
);
   initial pin = 2'h0;
   // Each pulse leaves the line at its old level, so edge counts stay exact
   task automatic burst(input int ch, input int n, input int hi, input int lo);
      repeat (n) begin
         @(negedge ref_clk) pin[ch] = ~pin[ch];
         repeat (hi) @(negedge ref_clk);
         pin[ch] = ~pin[ch];
         repeat (lo) @(negedge ref_clk);
      end
   endtask : burst
   task automatic flip(input int ch);
      @(negedge ref_clk) pin[ch] = ~pin[ch];
   endtask : flip
endmodule : pic_pulse_src
`default_nettype wire

// >>> bench/pic_counter_tb.sv
// Self-checking bench for the pulse integration counter
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module pic_counter_tb;
   localparam logic [31:0] SC [5] = '{32'h000009C4, 32'h000061A8, 32'h0003D090,
                                      32'h004C4B40, 32'h07735940};
   logic ref_clk = 1'b0, rstn = 1'b0, meas_run = 1'b1, logic_meas_en;
   logic logic_group_first_en = 1'b0, logic_group_second_en = 1'b0;
   logic [1:0] trig_source = 2'h0, cfg_filter = 2'h0, cfg_fall = 2'h0;
   logic [1:0] cfg_trig_timing = 2'h0, cfg_wrap = 2'h0, pin;
   logic [2:0] ctl = 3'h0;
   logic [3:0] cfg_mode = 4'h0;
   logic [5:0] cfg_range = 6'h0;
   logic [31:0] cfg_division = 32'h00010001;
   logic [63:0] chan_value, chan_full_scale, e_v, exp_q [$];
   logic [7:0] seed = 8'h33;
   int miscompares = 0, n_compared = 0, a, b;
   always #2.5 ref_clk = ~ref_clk;
   pic_pulse_src i_pic_pulse_src (.ref_clk, .pin);
   pic_counter #(.TICK_CYC(100), .CHATTER_CYC(8)) i_pic_counter (.ref_clk, .rstn,
      .pulse_input_pin(pin), .meas_start(ctl[0]), .meas_run, .sample_strobe(ctl[1]),
      .trig_event(ctl[2]), .trig_source, .cfg_mode, .cfg_range, .cfg_filter, .cfg_division,
      .cfg_fall, .cfg_trig_timing, .cfg_wrap, .logic_group_first_en, .logic_group_second_en,
      .logic_meas_en, .chan_value, .chan_full_scale);
   function automatic int rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return int'(seed % 8'h0C) + 2;
   endfunction : rnd
   task automatic blip(input int k);
      @(negedge ref_clk) ctl[k] = 1'b1;
      @(negedge ref_clk) ctl[k] = 1'b0;
   endtask : blip
   // Settle past the input synchroniser and filter, then sample
   task automatic sample(input logic [63:0] e);
      repeat (20) @(negedge ref_clk);
      exp_q.push_back(e);
      blip(1);
   endtask : sample
   task automatic both(input int n);
      i_pic_pulse_src.burst(0, n, 2, 2);
      i_pic_pulse_src.burst(1, n, 2, 2);
   endtask : both
   task automatic end_of_test();
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk) if (ctl[1]) begin
      @(negedge ref_clk);
      e_v = exp_q.pop_front();
      `CHK(chan_value, e_v)
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      end_of_test();
   end
   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial begin
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      `CHK(chan_full_scale, {SC[0], SC[0]})
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk) {logic_group_second_en, logic_group_first_en} = i[1:0];
         @(posedge ref_clk) `CHK(logic_meas_en, |i[1:0])
      end
      @(negedge ref_clk);
      cfg_fall = 2'h2;
      cfg_wrap = 2'h1;
      cfg_division = 32'h00030001;
      blip(0);
      i_pic_pulse_src.flip(1);
      a = rnd();
      b = rnd();
      i_pic_pulse_src.burst(0, a, 2, 2);
      // Remainder of two: counting the rising edges instead would give one unit more
      i_pic_pulse_src.burst(1, 3 * b + 2, 2, 2);
      sample({32'(b), 32'(a)});
      i_pic_pulse_src.burst(0, 5, 2, 2);
      sample({32'(b), 32'(a + 5)});
      for (int r = 0; r < 5; r++) begin
         cfg_range = {3'(4 - r), r[2:0]};
         repeat (2) @(negedge ref_clk);
         `CHK(chan_full_scale, {SC[4 - r], SC[r]})
      end
      {cfg_range, cfg_fall, cfg_wrap, cfg_mode, cfg_filter} = {6'h0, 2'h0, 2'h0, 4'h1, 2'h1};
      cfg_division = 32'h00010001;
      blip(0);
      a = rnd();
      i_pic_pulse_src.burst(0, 1, 1, 20);
      i_pic_pulse_src.burst(1, 1, 1, 20);
      i_pic_pulse_src.burst(0, a, 20, 20);
      i_pic_pulse_src.burst(1, a, 2, 2);
      sample({32'(a + 1), 32'(a)});
      b = rnd();
      i_pic_pulse_src.burst(0, b, 20, 20);
      sample({32'(a + 1), 32'(b)});
      {cfg_mode, cfg_filter, cfg_trig_timing, trig_source} = {4'h0, 2'h0, 2'h3, 2'h1};
      blip(0);
      a = rnd();
      both(a);
      repeat (20) @(negedge ref_clk);
      blip(2);
      sample({32'h0, 32'(a)});
      b = rnd();
      both(b);
      sample({32'(b), 32'(b)});
      {cfg_mode, cfg_range, cfg_trig_timing, trig_source} = {4'hF, 6'h24, 2'h0, 2'h0};
      repeat (2) @(negedge ref_clk);
      `CHK(chan_full_scale, {32'h000000FA, 32'h000000FA})
      blip(0);
      a = rnd();
      i_pic_pulse_src.burst(0, a, 2, 2);
      repeat (300) @(negedge ref_clk);
      sample({32'h0, 32'(a)});
      repeat (10100) @(negedge ref_clk);
      sample(64'h0);
      repeat (5) @(negedge ref_clk);
      end_of_test();
   end
endmodule : pic_counter_tb
bind pic_counter pic_counter_monitor i_pic_counter_monitor (.ref_clk, .rstn, .meas_start,
   .sample_strobe, .trig_event, .trig_source, .cfg_mode, .cfg_range, .cfg_trig_timing,
   .cfg_wrap, .logic_group_first_en, .logic_group_second_en, .logic_meas_en, .chan_value,
   .chan_full_scale);
`default_nettype wire
